// ---- tb_test_port_and_code_a_control.sv ----
// Self-checking bench for the test port control registers
`timescale 1ns/10ps
module tb_test_port_and_code_a_control;
   typedef struct {
      logic [5:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } tpc_tb_row_t;
   logic             clk;
   logic             rst;
   logic [5:0]       regAddr;
   logic [7:0]       regWrData;
   logic             regWrEn;
   logic             regRdEn;
   logic [7:0]       regRdData;
   logic             hostSerialActive;
   logic [4:0]       probeBusSelect;
   logic [31:0][7:0] probeSrc;
   logic             delimWidth;
   logic             crcCmd;
   logic [5:0]       pinIn, pinOut, pinOe, extVal;
   logic             uartAuxEnable, rxNonlinear, selfTestEnable;
   logic             selfTestStart, crcStart;
   logic [11:0]      sofHighLen, sofLowLen, eofLowLen;
   logic [11:0]      expHi [3];
   logic [11:0]      expLo [3];
   int               mismatches, cmpCount, nSt, nCrc;
   // Row 0x35 expects source 7, row 0x30 is unmapped
   tpc_tb_row_t      rows [6];

   tpc_test_port_ctrl DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .hostSerialActive(hostSerialActive),
      .probeBusSelect(probeBusSelect), .probeSrc(probeSrc),
      .delimWidth(delimWidth), .crcCmd(crcCmd), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .uartAuxEnable(uartAuxEnable),
      .rxNonlinear(rxNonlinear), .selfTestEnable(selfTestEnable),
      .selfTestStart(selfTestStart), .crcStart(crcStart),
      .sofHighLen(sofHighLen), .sofLowLen(sofLowLen),
      .eofLowLen(eofLowLen));

   tpc_pin_partner partner (.pinOut(pinOut), .pinOe(pinOe),
      .extVal(extVal), .pinLevel(pinIn));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic fail(input string msg);
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
   endtask

   task automatic chkSig(input logic [11:0] got, input logic [11:0] exp,
                         input string what);
      cmpCount++;
      if (got !== exp) fail($sformatf("%s got %h want %h", what, got, exp));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      regAddr = a;
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      cmpCount++;
      if (regRdData !== e) fail($sformatf("read %h got %h want %h",
                                          a, regRdData, e));
      cyc(1);
   endtask

   // Start pulses counted over the three edges after the command
   task automatic crcPulse;
      crcCmd = 1'b1;
      cyc(1);
      crcCmd = 1'b0;
      nSt = 0;
      nCrc = 0;
      repeat (3) begin
         if (selfTestStart === 1'b1) nSt++;
         if (crcStart === 1'b1) nCrc++;
         cyc(1);
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Whole run is well under a thousand cycles
   initial begin
      #(4000 * 50);
      fail("timeout");
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      regAddr = 6'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      hostSerialActive = 1'b0;
      probeBusSelect = 5'h07;
      for (int i = 0; i < 32; i++) probeSrc[i] = 8'h10 + 8'(i);
      delimWidth = 1'b0;
      crcCmd = 1'b0;
      extVal = 6'h00;
      rows = '{'{6'h33, 8'h01, 8'h00}, '{6'h33, 8'hFF, 8'hFE},
               '{6'h34, 8'h7F, 8'h7E}, '{6'h36, 8'h2B, 8'h2B},
               '{6'h35, 8'h55, 8'h17}, '{6'h30, 8'hAA, 8'h00}};
      expHi = '{12'h100, 12'h180, 12'h108};
      expLo = '{12'h500, 12'h580, 12'h578};
      repeat (6) @(posedge clk);
      #2 rst = 1'b0;
      chkSig(uartAuxEnable, 1'b1, "aux lines");
      chkSig(pinOe, 6'h00, "enables");
      chkSig(rxNonlinear, 1'b1, "nonlinear");
      chkSig(selfTestEnable, 1'b0, "self-test");
      rd(6'h33, 8'h80);
      rd(6'h34, 8'h00);
      rd(6'h36, 8'h40);
      $display("Test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      $display("Test register table done");
      probeBusSelect = 5'h00;
      rd(6'h35, 8'h10);
      probeBusSelect = 5'h1F;
      rd(6'h35, 8'h2F);
      wr(6'h33, 8'h02);
      cyc(2);
      chkSig(pinOe, 6'h01, "enable D1");
      chkSig(uartAuxEnable, 1'b0, "aux off");
      wr(6'h33, 8'hA0);
      cyc(2);
      chkSig(pinOe, 6'h10, "enable D5");
      chkSig(uartAuxEnable, 1'b1, "aux on");
      $display("Test driver enables done");
      hostSerialActive = 1'b1;
      extVal = 6'h20;
      // only D1 to D4 enabled under a serial host
      wr(6'h33, 8'h9E);
      wr(6'h34, 8'h8A);
      cyc(2);
      chkSig(pinOe, 6'h0F, "io enables");
      chkSig(pinOut & pinOe, 6'h05, "io drive");
      cyc(6);
      rd(6'h34, 8'hCA);
      extVal = 6'h00;
      cyc(6);
      rd(6'h34, 8'h8A);
      hostSerialActive = 1'b0;
      cyc(2);
      chkSig(pinOut & pinOe, 6'h0F, "probe drive");
      wr(6'h34, 8'h0A);
      rd(6'h34, 8'h0A);
      $display("Test io mode done");
      for (int k = 0; k < 3; k++) begin
         wr(6'h36, {1'b0, k != 0, 1'b0, k == 2, 4'h0});
         delimWidth = (k != 0);
         cyc(3);
         chkSig(rxNonlinear, k != 0, "nonlinear");
         chkSig(sofHighLen, expHi[k], "sof high");
         chkSig(sofLowLen, expLo[k], "sof low");
         chkSig(eofLowLen, expLo[k], "eof low");
      end
      $display("Test delimiters done");
      for (int c = 0; c < 16; c++) begin
         wr(6'h36, {4'h4, 4'(c)});
         cyc(2);
         chkSig(selfTestEnable, c == 9, "enable code");
         crcPulse();
         chkSig(12'(nSt), c == 9, "self-test start");
         chkSig(12'(nCrc), c != 9, "crc start");
      end
      wr(6'h36, 8'h40);
      cyc(2);
      chkSig(selfTestEnable, 1'b0, "self-test off");
      $display("Test self-test done");
      print_verdict();
   end
endmodule

// ---- tpc_delim_calc.sv ----
// Type B start and end delimiter phase lengths in clocks
`timescale 1ns/10ps
`include "tpc_map.svh"
module tpc_delim_calc (
   input wire logic clk,
   input wire logic rst,
   tpc_delim_if.calc dl
);
   logic [11:0] hiEtu;
   logic [11:0] loEtu;

   always_comb begin
      hiEtu = dl.width ? `TPC_SOF_HI_MAX : `TPC_SOF_HI_MIN;
      loEtu = dl.width ? `TPC_LOW_MAX : `TPC_LOW_MIN;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dl.sofHigh <= 12'h000;
         dl.sofLow  <= 12'h000;
         dl.eofLow  <= 12'h000;
      end else if (dl.adjust && dl.width) begin
         // RULE_12: trimmed phases
         dl.sofHigh <= 12'(`TPC_SOF_HI_MIN * `TPC_ETU_CLKS + `TPC_ADJ_CLKS);
         dl.sofLow  <= 12'(`TPC_LOW_MAX * `TPC_ETU_CLKS - `TPC_ADJ_CLKS);
         dl.eofLow  <= 12'(`TPC_LOW_MAX * `TPC_ETU_CLKS - `TPC_ADJ_CLKS);
      end else begin
         // RULE_11: max or min by width
         dl.sofHigh <= 12'(hiEtu * `TPC_ETU_CLKS);
         dl.sofLow  <= 12'(loEtu * `TPC_ETU_CLKS);
         dl.eofLow  <= 12'(loEtu * `TPC_ETU_CLKS);
      end
   end
endmodule

// ---- tpc_delim_if.sv ----
// Delimiter settings and resulting phase lengths
`timescale 1ns/10ps
interface tpc_delim_if;
   logic        adjust;
   logic        width;
   logic [11:0] sofHigh;
   logic [11:0] sofLow;
   logic [11:0] eofLow;
   modport ctrl (output adjust, output width,
                 input sofHigh, input sofLow, input eofLow);
   modport calc (input adjust, input width,
                 output sofHigh, output sofLow, output eofLow);
endinterface

// ---- tpc_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

`define TPC_OFF_PIN_EN    6'h33
`define TPC_OFF_PIN_VAL   6'h34
`define TPC_OFF_PROBE     6'h35
`define TPC_OFF_CODE_A  6'h36

`define TPC_RST_PIN_EN    8'h80
`define TPC_RST_PIN_VAL   8'h00
`define TPC_RST_CODE_A  8'h40

`define TPC_MASK_PIN_EN   8'hFE
`define TPC_MASK_PIN_VAL  8'hFE
`define TPC_MASK_CODE_A 8'hFF

`define TPC_B_UART_EN     7
`define TPC_B_USE_IO      7
`define TPC_B_NONLINEAR   6
`define TPC_B_DELIM_ADJ   4
`define TPC_F_PINS        6:1
`define TPC_F_CODE        3:0

`define TPC_CODE_CODE_A 4'h9
`define TPC_CODE_OFF      4'h0

`define TPC_ETU_CLKS      12'h080
`define TPC_ADJ_CLKS      12'h008
`define TPC_SOF_HI_MIN    12'h002
`define TPC_SOF_HI_MAX    12'h003
`define TPC_LOW_MIN       12'h00A
`define TPC_LOW_MAX       12'h00B

`endif

// ---- tpc_pin_partner.sv ----
// External circuitry on the data test pins
`timescale 1ns/10ps
module tpc_pin_partner (
   input  wire logic [5:0] pinOut,
   input  wire logic [5:0] pinOe,
   input  wire logic [5:0] extVal,
   output logic      [5:0] pinLevel
);
   // Circuitry drives only pins the device leaves undriven
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

// ---- tpc_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the data pins
`timescale 1ns/10ps
module tpc_pin_sync (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] pinIn,
   output logic      [5:0] pinLevel
);
   logic [5:0] s1Q;
   logic [5:0] s2Q;
   logic [5:0] s3Q;

   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : gBit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1Q[i]      <= 1'b0;
               s2Q[i]      <= 1'b0;
               s3Q[i]      <= 1'b0;
               pinLevel[i] <= 1'b0;
            end else begin
               s1Q[i] <= pinIn[i];
               s2Q[i] <= s1Q[i];
               s3Q[i] <= s2Q[i];
               // Only a level seen on two stages in a row counts
               if (s2Q[i] == s3Q[i]) begin
                  pinLevel[i] <= s3Q[i];
               end
            end
         end
      end
   endgenerate
endmodule

// ---- tpc_pkg.sv ----
// Types shared by the test port control block
package tpc_pkg;
   typedef enum logic [2:0] {
      TPC_R_NONE     = 3'b000,
      TPC_R_PIN_EN   = 3'b001,
      TPC_R_PIN_VAL  = 3'b010,
      TPC_R_PROBE    = 3'b011,
      TPC_R_CODE_A = 3'b100
   } tpc_reg_t;

   typedef enum logic [1:0] {
      TPC_C_IDLE  = 2'b00,
      TPC_C_CRC   = 2'b01,
      TPC_C_TEST  = 2'b10
   } tpc_cmd_t;
endpackage

// ---- tpc_test_port_ctrl.sv ----
// Test port, probe view and self-test control registers
//
// Function
// RULE_01: Bit 7 of driver enable clear disables both auxiliary UART lines.
// RULE_02: Enable bits 6..1 switch on the matching data pin driver.
// RULE_03: With SPI host, software enables outputs only on pins one to four.
// RULE_04: With UART and auxiliary lines on, only pins one to four used. Code still enables D5 and D6 from bits 5 and 6 while bit 7 is set.
// RULE_05: I/O-use bit makes the port general I/O under serial host.
// RULE_06: In I/O mode enabled pins drive their pin value bits.
// RULE_07: Pin value read gives live pins in I/O mode, else stored bits. Code returns live pins whenever bit 7 is set, with or without serial host.
// RULE_08: Probe bus view is read-only; writes ignored; reset value undefined.
// RULE_09: Probe bus source chosen by a separate five-bit select field.
// RULE_10: Nonlinear bit set selects nonlinear receive processing at 106 kBd.
// RULE_11: Adjust clear: width bit picks maximum or minimum type B delimiters.
// RULE_12: Adjust and width set: high 2 ETU+8, lows 11 ETU-8 clocks.
// RULE_13: Self-test enabled only while the four-bit code equals 1001b.
// RULE_14: CRC command starts the self-test run while self-test enabled.
// RULE_15: Software writes 0000b to the code for normal operation.
// RULE_16: Driver enable register resets to 80h.
// RULE_17: Self-test control register resets to 40h.
// RULE_18: Pin value register resets to 00h.
// RULE_19: Reserved bits ignore writes and read zero, production bits kept.
`timescale 1ns/10ps
`include "tpc_map.svh"
module tpc_test_port_ctrl
   import tpc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [5:0]       regAddr,
   input  wire logic [7:0]       regWrData,
   input  wire logic             regWrEn,
   input  wire logic             regRdEn,
   output logic      [7:0]       regRdData,
   input  wire logic             hostSerialActive,
   input  wire logic [4:0]       probeBusSelect,
   input  wire logic [31:0][7:0] probeSrc,
   input  wire logic             delimWidth,
   input  wire logic             crcCmd,
   input  wire logic [5:0]       pinIn,
   output logic      [5:0]       pinOut,
   output logic      [5:0]       pinOe,
   output logic                  uartAuxEnable,
   output logic                  rxNonlinear,
   output logic                  selfTestEnable,
   output logic                  selfTestStart,
   output logic                  crcStart,
   output logic      [11:0]      sofHighLen,
   output logic      [11:0]      sofLowLen,
   output logic      [11:0]      eofLowLen
);
   logic [7:0] pinEnQ;
   logic [7:0] pinValQ;
   logic [7:0] selfTestQ;
   logic [5:0] pinLevel;
   logic [7:0] probeView;
   logic [7:0] rdMux;
   logic       ioMode;
   tpc_reg_t   wrSel;
   tpc_reg_t   rdSel;
   tpc_cmd_t   cmdD;

   tpc_delim_if dl ();

   // Shared by the write and the read path
   function automatic tpc_reg_t decodeReg(input logic [5:0] addr);
      case (addr)
         `TPC_OFF_PIN_EN:   decodeReg = TPC_R_PIN_EN;
         `TPC_OFF_PIN_VAL:  decodeReg = TPC_R_PIN_VAL;
         `TPC_OFF_PROBE:    decodeReg = TPC_R_PROBE;
         `TPC_OFF_CODE_A: decodeReg = TPC_R_CODE_A;
         default:           decodeReg = TPC_R_NONE;
      endcase
   endfunction

   tpc_pin_sync uSync (
      .clk      (clk),
      .rst      (rst),
      .pinIn    (pinIn),
      .pinLevel (pinLevel)
   );

   tpc_delim_calc uDelim (
      .clk (clk),
      .rst (rst),
      .dl  (dl.calc)
   );

   assign wrSel = regWrEn ? decodeReg(regAddr) : TPC_R_NONE;
   assign rdSel = regRdEn ? decodeReg(regAddr) : TPC_R_NONE;
   // RULE_05: I/O mode needs a serial host
   assign ioMode = pinValQ[`TPC_B_USE_IO] & hostSerialActive;
   // RULE_09: probe source by select field
   assign probeView = probeSrc[probeBusSelect];
   assign dl.adjust = selfTestQ[`TPC_B_DELIM_ADJ];
   assign dl.width  = delimWidth;
   assign sofHighLen = dl.sofHigh;
   assign sofLowLen  = dl.sofLow;
   assign eofLowLen  = dl.eofLow;

   // RULE_16: driver enable reset value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinEnQ <= `TPC_RST_PIN_EN;
      end else if (wrSel == TPC_R_PIN_EN) begin
         // RULE_19: reserved bit forced zero
         pinEnQ <= regWrData & `TPC_MASK_PIN_EN;
      end
   end

   // RULE_18: pin value reset value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinValQ <= `TPC_RST_PIN_VAL;
      end else if (wrSel == TPC_R_PIN_VAL) begin
         pinValQ <= regWrData & `TPC_MASK_PIN_VAL;
      end
   end

   // RULE_17: self-test control reset value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selfTestQ <= `TPC_RST_CODE_A;
      end else if (wrSel == TPC_R_CODE_A) begin
         // Production bits 7 and 5 are kept as written
         selfTestQ <= regWrData & `TPC_MASK_CODE_A;
      end
   end

   always_comb begin
      case (rdSel)
         TPC_R_PIN_EN:   rdMux = pinEnQ;
         // RULE_07: live pins whenever I/O-use bit 7 is set, serial host or not
         TPC_R_PIN_VAL:  rdMux = pinValQ[`TPC_B_USE_IO] ?
                                 {1'b1, pinLevel, 1'b0} : pinValQ;
         // RULE_08: probe view, no storage behind it
         TPC_R_PROBE:    rdMux = probeView;
         TPC_R_CODE_A: rdMux = selfTestQ;
         default:        rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= rdMux;
      end
   end

   // RULE_01: auxiliary UART line gating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         uartAuxEnable <= 1'b1;
      end else begin
         uartAuxEnable <= pinEnQ[`TPC_B_UART_EN];
      end
   end

   // RULE_02: per-pin driver enables
   // RULE_03: upper pins left to software discipline
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinOe <= 6'h00;
      end else begin
         pinOe <= pinEnQ[`TPC_F_PINS];
      end
   end

   // RULE_06: driven value in I/O mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinOut <= 6'h00;
      end else if (ioMode) begin
         pinOut <= pinValQ[`TPC_F_PINS];
      end else begin
         pinOut <= probeView[5:0];
      end
   end

   // RULE_10: receiver nonlinear mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxNonlinear <= 1'b1;
      end else begin
         rxNonlinear <= selfTestQ[`TPC_B_NONLINEAR];
      end
   end

   // RULE_13: exact code enables self-test
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selfTestEnable <= 1'b0;
      end else begin
         selfTestEnable <= (selfTestQ[`TPC_F_CODE] == `TPC_CODE_CODE_A);
      end
   end

   // RULE_14: CRC command redirected to self-test
   always_comb begin
      case ({crcCmd, selfTestEnable})
         2'b10:   cmdD = TPC_C_CRC;
         2'b11:   cmdD = TPC_C_TEST;
         default: cmdD = TPC_C_IDLE;
      endcase
   end

   // Start pulses leave from flops, no decode glitch at the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crcStart      <= 1'b0;
         selfTestStart <= 1'b0;
      end else begin
         crcStart      <= (cmdD == TPC_C_CRC);
         selfTestStart <= (cmdD == TPC_C_TEST);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   uart_aux_gate_a: assert property ( // RULE_01
      ##1 uartAuxEnable == $past(pinEnQ[`TPC_B_UART_EN]))
      else $error("aux UART enable does not follow bit 7");

   pin_oe_write_a: assert property ( // RULE_02
      (wrSel == TPC_R_PIN_EN) |-> ##2 pinOe == $past(regWrData[6:1], 2))
      else $error("pin driver enables do not follow write");

   pin_io_drive_a: assert property ( // RULE_06
      ioMode |=> pinOut == $past(pinValQ[6:1]))
      else $error("I/O mode pin value not driven");

   io_needs_host_a: assert property ( // RULE_05
      !hostSerialActive |=> pinOut == $past(probeView[5:0]))
      else $error("I/O mode active without serial host");

   pin_val_store_a: assert property ( // RULE_07
      (wrSel == TPC_R_PIN_VAL)
      |=> pinValQ == ($past(regWrData) & 8'hFE))
      else $error("pin value register not stored as written");

   probe_no_store_a: assert property ( // RULE_08
      (wrSel == TPC_R_PROBE)
      |=> $stable(pinEnQ) && $stable(pinValQ) && $stable(selfTestQ))
      else $error("write to probe view changed a register");

   pin_live_read_a: assert property ( // RULE_07
      (rdSel == TPC_R_PIN_VAL && pinValQ[7])
      |=> regRdData == {1'b1, $past(pinLevel), 1'b0})
      else $error("live pin levels not returned");

   pin_stored_read_a: assert property ( // RULE_07
      (rdSel == TPC_R_PIN_VAL && !pinValQ[7])
      |=> regRdData == $past(pinValQ))
      else $error("stored pin value not returned");

   probe_view_a: assert property ( // RULE_09
      (rdSel == TPC_R_PROBE)
      |=> regRdData == $past(probeSrc[probeBusSelect]))
      else $error("probe view does not match selected source");

   rx_nonlinear_a: assert property ( // RULE_10
      ##1 rxNonlinear == $past(selfTestQ[6]))
      else $error("nonlinear flag does not follow register");

   delim_trim_a: assert property ( // RULE_12
      (dl.adjust && dl.width)
      |=> sofHighLen == 12'(2 * 128 + 8) && sofLowLen == 12'(11 * 128 - 8))
      else $error("trimmed delimiter lengths wrong");

   delim_minmax_a: assert property ( // RULE_11
      (!dl.adjust) |=> eofLowLen == ($past(dl.width) ? 12'd1408 : 12'd1280))
      else $error("delimiter max or min length wrong");

   code_a_code_a: assert property ( // RULE_13
      ##1 selfTestEnable == ($past(selfTestQ[3:0]) == 4'h9))
      else $error("self-test enable not tied to code 1001b");

   code_a_start_a: assert property ( // RULE_14
      (crcCmd && selfTestEnable) |=> selfTestStart && !crcStart)
      else $error("CRC command did not start self-test");

   crc_normal_a: assert property ( // RULE_14
      (crcCmd && !selfTestEnable) |=> crcStart && !selfTestStart)
      else $error("CRC command did not start CRC");

   no_start_idle_a: assert property ( // RULE_14
      !crcCmd |=> !crcStart && !selfTestStart)
      else $error("start pulse without CRC command");

   start_exclusive_a: assert property ( // RULE_14
      ##1 !(crcStart && selfTestStart))
      else $error("CRC and self-test started together");

   reset_values_a: assert property ( // RULE_16
      $fell(rst) |-> pinEnQ == 8'h80 && pinValQ == 8'h00
                     && selfTestQ == 8'h40)
      else $error("register reset values wrong");

   reserved_zero_a: assert property ( // RULE_19
      (rdSel == TPC_R_PIN_EN || rdSel == TPC_R_PIN_VAL)
      |=> !regRdData[0])
      else $error("reserved bit 0 reads nonzero");

endmodule
